// *** pkg/gpp_defs.svh ***
// Purpose: address map, field positions and reset values of the gpio/pad block
// Assumes: 16-bit paddr, one 32-bit word per register
// Notes:   port n sits at n*0x1000, pad unit at 0x3000
`ifndef GPP_DEFS_SVH
`define GPP_DEFS_SVH
`define GPP_PORTS        3
`define GPP_PADS         48
`define GPP_PIN_PRESENT  48'hFF7F_000F_7FFF
`define GPP_REGION_PAD   2'h3
// offsets inside one port region
`define GPP_P_DATAIN     12'h000
`define GPP_P_DATAOUT    12'h004
`define GPP_P_OUTSET     12'h008
`define GPP_P_OUTCLR     12'h00C
`define GPP_P_OUTEN      12'h010
`define GPP_P_INTEN      12'h014
`define GPP_P_INTRISE    12'h018
`define GPP_P_INTFALL    12'h01C
`define GPP_P_INTSTAT    12'h020
`define GPP_WIN_LOW_SEL  2'h1
`define GPP_WIN_HIGH_SEL 2'h2
// offsets inside the pad region
`define GPP_U_CFG_PAGE   4'h0
`define GPP_U_EXTMASK    12'h100
`define GPP_U_EXTPOL     12'h110
`define GPP_U_TERMS      12'h120
`define GPP_U_SUMMARY    12'h130
// pad config word fields
`define GPP_CFG_W        7
`define GPP_CFG_FUNC     1:0
`define GPP_CFG_IE       2
`define GPP_CFG_CS       3
`define GPP_CFG_PU       4
`define GPP_CFG_PD       5
`define GPP_CFG_DS       6
`define GPP_CFG_RST      7'h04
`endif

// *** pkg/gpp_pkg.sv ***
// Purpose: shared types of the gpio/pad block
// Assumes: nothing
// Notes:   function select codes follow declaration order
`default_nettype none
package gpp_pkg;
    typedef enum logic [1:0] {
        GPP_FN_NORMAL,
        GPP_FN_PORT,
        GPP_FN_THIRD,
        GPP_FN_FOURTH
    } gpp_func_type;
endpackage
`default_nettype wire

// *** logic/gpp_port.sv ***
// Purpose: one 16-bit port: output latch, enables, edge interrupts, masked windows
// Assumes: pinIn already synchronised and input-buffer gated
// Notes:   read data is combinational, the bus slave registers it
`timescale 1ns/1ns
`default_nettype none
`include "gpp_defs.svh"
module gpp_port import gpp_pkg::*; #(
    parameter logic [15:0] PRESENT = 16'hFFFF
) (
    input  wire logic        clock,    // system clock
    input  wire logic        srst,     // sync reset
    input  wire logic        ce,       // clock enable
    input  wire logic        wrEn,     // write strobe for this port
    input  wire logic [11:0] addr,     // offset in port region
    input  wire logic [31:0] wdata,    // write data
    input  wire logic [15:0] pinIn,    // gated pin levels
    output logic      [31:0] rdata,    // read data
    output logic             hit,      // offset is mapped
    output logic      [15:0] outLatch, // output latch
    output logic      [15:0] outEn,    // output enables
    output logic             irq       // port interrupt level
);
    logic [15:0] out_reg, oe_reg, inten_reg, rise_reg, fall_reg, stat_reg, prev_reg;
    logic [15:0] out_next, stat_next;
    wire        winLow   = addr[11:10] == `GPP_WIN_LOW_SEL;
    wire        winHigh  = addr[11:10] == `GPP_WIN_HIGH_SEL;
    wire [15:0] fullMask = winLow ? {8'h00, addr[9:2]} : {addr[9:2], 8'h00};
    wire        isOut  = addr == `GPP_P_DATAOUT;
    wire        isSet  = addr == `GPP_P_OUTSET;
    wire        isClr  = addr == `GPP_P_OUTCLR;
    wire        isOe   = addr == `GPP_P_OUTEN;
    wire        isIen  = addr == `GPP_P_INTEN;
    wire        isRise = addr == `GPP_P_INTRISE;
    wire        isFall = addr == `GPP_P_INTFALL;
    wire        isStat = addr == `GPP_P_INTSTAT;
    wire        isIn   = addr == `GPP_P_DATAIN;
    wire        isWin  = winLow | winHigh;
    wire [15:0] wd     = wdata[15:0] & PRESENT;
    // edge detection on the gated level; disabling a buffer on a high pin gives one falling edge, then none
    wire [15:0] evt = ((pinIn & ~prev_reg & rise_reg)
                     | (~pinIn & prev_reg & fall_reg)) & PRESENT;
    wire [15:0] w1c = (wrEn & isStat) ? wd : 16'h0000;
    assign out_next = !wrEn ? out_reg
                    : isOut ? wd
                    : isSet ? (out_reg | wd)
                    : isClr ? (out_reg & ~wd)
                    : isWin ? ((out_reg & ~fullMask) | (wd & fullMask))
                    : out_reg;
    // a new edge wins over a write-one-to-clear in the same cycle
    assign stat_next = (stat_reg & ~w1c) | evt;
    assign hit = isIn | isOut | isSet | isClr | isOe | isIen | isRise | isFall
               | isStat | isWin;
    assign rdata = isIn   ? {16'h0000, pinIn & PRESENT}
                 : isOut  ? {16'h0000, out_reg}
                 : isOe   ? {16'h0000, oe_reg}
                 : isIen  ? {16'h0000, inten_reg}
                 : isRise ? {16'h0000, rise_reg}
                 : isFall ? {16'h0000, fall_reg}
                 : isStat ? {16'h0000, stat_reg}
                 : isWin  ? {16'h0000, pinIn & PRESENT & fullMask}
                 : 32'h0000_0000;
    assign outLatch = out_reg;
    assign outEn    = oe_reg;
    assign irq      = |(stat_reg & inten_reg);
    always_ff @(posedge clock) begin
        if (srst) begin
            out_reg   <= 16'h0000;
            oe_reg    <= 16'h0000;
            inten_reg <= 16'h0000;
            rise_reg  <= 16'h0000;
            fall_reg  <= 16'h0000;
            stat_reg  <= 16'h0000;
            prev_reg  <= 16'h0000;
        end else if (ce) begin
            out_reg  <= out_next;
            stat_reg <= stat_next;
            prev_reg <= pinIn;
            if (wrEn && isOe)   oe_reg    <= wd;
            if (wrEn && isIen)  inten_reg <= wd;
            if (wrEn && isRise) rise_reg  <= wd;
            if (wrEn && isFall) fall_reg  <= wd;
        end
    end
endmodule
`default_nettype wire

// *** logic/gpp_top.sv ***
// Purpose: gpio ports, pad config unit and pad interrupt unit behind APB
// Assumes: padIn is asynchronous to clock; APB3 master, no byte strobes
// Notes:   read data sampled in setup phase, zero wait states while ce is high
`timescale 1ns/1ns
`default_nettype none
`include "gpp_defs.svh"
module gpp_top import gpp_pkg::*; (
    input  wire logic        clock,            // 100 MHz system clock
    input  wire logic        srst,             // sync reset, active high
    input  wire logic        ce,               // clock enable, freezes all state
    input  wire logic        psel,             // APB select
    input  wire logic        penable,          // APB enable
    input  wire logic        pwrite,           // APB direction
    input  wire logic [15:0] paddr,            // APB byte address
    input  wire logic [31:0] pwdata,           // APB write data
    output logic      [31:0] prdata,           // APB read data
    output logic             pready,           // APB ready
    output logic             pslverr,          // APB error, unmapped address
    input  wire logic [47:0] padIn,            // raw pad levels
    output logic      [47:0] padOut,           // port output latch per pad
    output logic      [47:0] padOutEn,         // port output enable per pad
    output logic      [95:0] padFuncSel,       // two bits per pad
    output logic      [47:0] input_buffer_en,  // input buffer enable per pad
    output logic      [47:0] schmittSel,       // 1 selects schmitt input
    output logic      [47:0] pullup_en,        // pull-up enable per pad
    output logic      [47:0] pulldown_en,      // pull-down enable per pad
    output logic      [47:0] drive_strength_sel, // 1 selects high drive
    output logic             combined_pad_irq, // pad interrupt line
    output logic             portIrq           // gpio port interrupt line
);
    localparam logic [47:0] PRESENT = `GPP_PIN_PRESENT;

    // pad input synchroniser
    logic [47:0] padMeta_reg;
    logic [47:0] padSync_reg;
    always_ff @(posedge clock) begin
        if (srst) begin
            padMeta_reg <= 48'h0000_0000_0000;
            padSync_reg <= 48'h0000_0000_0000;
        end else if (ce) begin
            padMeta_reg <= padIn;
            padSync_reg <= padMeta_reg;
        end
    end

    // APB decode
    wire        accessPh = psel & penable;
    wire [1:0]  region   = paddr[13:12];
    wire [11:0] offs     = paddr[11:0];
    wire        highZero = paddr[15:14] == 2'h0;
    wire        isPadReg = highZero & (region == `GPP_REGION_PAD);
    wire        isPortRg = highZero & (region != `GPP_REGION_PAD);
    wire        wrStrobe = accessPh & pwrite & ce;

    // pad config unit registers
    logic [`GPP_CFG_W-1:0] padCfg_reg [`GPP_PADS];
    logic [47:0]           extMask_reg;
    logic [47:0]           extPol_reg;

    wire [5:0] padIdx   = offs[7:2];
    wire       isCfg    = (offs[11:8] == `GPP_U_CFG_PAGE) & (padIdx < 6'(`GPP_PADS));
    wire       isMaskR  = (offs >= `GPP_U_EXTMASK) & (offs < `GPP_U_EXTMASK + 12'h00C);
    wire       isPolR   = (offs >= `GPP_U_EXTPOL) & (offs < `GPP_U_EXTPOL + 12'h00C);
    wire       isTermR  = (offs >= `GPP_U_TERMS) & (offs < `GPP_U_TERMS + 12'h00C);
    wire       isSumR   = offs == `GPP_U_SUMMARY;
    wire [1:0] subPort  = offs[3:2];
    wire       padHit   = isCfg | isMaskR | isPolR | isTermR | isSumR;
    wire       wrCfg    = wrStrobe & isPadReg & isCfg;
    wire       wrMask   = wrStrobe & isPadReg & isMaskR;
    wire       wrPol    = wrStrobe & isPadReg & isPolR;

    // gated digital inputs seen by the ports
    logic [47:0] ieVec;
    wire  [47:0] padY = padSync_reg & ieVec;

    // pad interrupt unit: raw level, so the selected function never hides a pad
    wire [47:0] padTerm = extMask_reg & (extPol_reg ^ padSync_reg) & PRESENT;
    assign combined_pad_irq = |padTerm;

    genvar p;
    generate
        for (p = 0; p < `GPP_PADS; p++) begin : g_pad
            wire [`GPP_CFG_W-1:0] cfg = padCfg_reg[p];
            assign ieVec[p]              = cfg[`GPP_CFG_IE];
            assign input_buffer_en[p]    = cfg[`GPP_CFG_IE];
            assign schmittSel[p]         = cfg[`GPP_CFG_CS];
            assign pullup_en[p]          = cfg[`GPP_CFG_PU];
            assign pulldown_en[p]        = cfg[`GPP_CFG_PD];
            assign drive_strength_sel[p] = cfg[`GPP_CFG_DS];
            assign padFuncSel[2*p +: 2]  = cfg[`GPP_CFG_FUNC];
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (srst) begin
            for (int i = 0; i < `GPP_PADS; i++) begin
                padCfg_reg[i] <= `GPP_CFG_RST;
            end
        end else if (wrCfg) begin
            padCfg_reg[padIdx] <= pwdata[`GPP_CFG_W-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            extMask_reg <= 48'h0000_0000_0000;
            extPol_reg  <= 48'h0000_0000_0000;
        end else begin
            if (wrMask) extMask_reg[16*subPort +: 16] <= pwdata[15:0];
            if (wrPol)  extPol_reg[16*subPort +: 16]  <= pwdata[15:0];
        end
    end

    // ports
    logic [31:0] portRd  [`GPP_PORTS];
    logic [2:0]  portHit;
    logic [2:0]  portIrqV;
    logic [47:0] latchVec;
    logic [47:0] oeVec;

    genvar g;
    generate
        for (g = 0; g < `GPP_PORTS; g++) begin : g_port
            gpp_port #(
                .PRESENT (PRESENT[16*g +: 16])
            ) u_port (
                .clock    (clock),
                .srst     (srst),
                .ce       (ce),
                .wrEn     (wrStrobe & isPortRg & (region == 2'(g))),
                .addr     (offs),
                .wdata    (pwdata),
                .pinIn    (padY[16*g +: 16]),
                .rdata    (portRd[g]),
                .hit      (portHit[g]),
                .outLatch (latchVec[16*g +: 16]),
                .outEn    (oeVec[16*g +: 16]),
                .irq      (portIrqV[g])
            );
        end
    endgenerate

    // port only drives a pad while that pad selects the port function
    generate
        for (p = 0; p < `GPP_PADS; p++) begin : g_drv
            assign padOutEn[p] = oeVec[p] & PRESENT[p]
                               & (padCfg_reg[p][`GPP_CFG_FUNC] == GPP_FN_PORT);
        end
    endgenerate
    assign padOut  = latchVec & PRESENT;
    assign portIrq = |portIrqV;

    // read mux
    wire [31:0] termWord = {16'h0000, padTerm[16*subPort +: 16]};
    wire [31:0] padRd = isCfg   ? {25'h0, padCfg_reg[padIdx]}
                      : isMaskR ? {16'h0000, extMask_reg[16*subPort +: 16]}
                      : isPolR  ? {16'h0000, extPol_reg[16*subPort +: 16]}
                      : isTermR ? termWord
                      : isSumR  ? {30'h0, portIrq, combined_pad_irq}
                      : 32'h0000_0000;
    wire        hitNow = isPadReg ? padHit : (isPortRg & portHit[region]);
    wire [31:0] rdNow  = isPadReg ? padRd : (isPortRg ? portRd[region] : 32'h0000_0000);

    // a read whose setup fell in a frozen cycle is captured late, one wait state
    logic [31:0] prdata_reg;
    logic        rdHeld_reg;
    wire         rdTake      = ce & psel & ~pwrite & ~rdHeld_reg;
    wire         rdHeld_next = psel & ~pwrite & ~(accessPh & rdHeld_reg);
    always_ff @(posedge clock) begin
        if (srst) begin
            prdata_reg <= 32'h0000_0000;
            rdHeld_reg <= 1'b0;
        end else if (ce) begin
            rdHeld_reg <= rdHeld_next;
            if (rdTake) prdata_reg <= hitNow ? rdNow : 32'h0000_0000;
        end
    end

    // ready waits for ce so a frozen block stalls the transfer instead of losing it
    assign prdata  = prdata_reg;
    assign pready  = ce & (pwrite | rdHeld_reg);
    assign pslverr = accessPh & ~hitNow;
endmodule
`default_nettype wire

// *** test/gpp_top_sva.sv ***
// Purpose: port-level checks of the gpio/pad block
// Assumes: one clock domain, bound into gpp_top
// Notes:   register contents are judged by the bench
`timescale 1ns/1ns
`default_nettype none
`include "gpp_defs.svh"
module gpp_top_chk import gpp_pkg::*; (
    input  wire logic        clock,            // clock
    input  wire logic        srst,             // reset
    input  wire logic        ce,               // enable
    input  wire logic        psel,             // select
    input  wire logic        penable,          // access
    input  wire logic        pwrite,           // direction
    input  wire logic [15:0] paddr,            // address
    input  wire logic [31:0] prdata,           // read data
    input  wire logic        pready,           // ready
    input  wire logic        pslverr,          // error
    input  wire logic [47:0] padIn,            // pad levels
    input  wire logic [47:0] padOut,           // latch
    input  wire logic [47:0] padOutEn,         // drive enables
    input  wire logic [95:0] padFuncSel,       // functions
    input  wire logic [47:0] input_buffer_en,  // buffers
    input  wire logic        combined_pad_irq, // pad irq
    input  wire logic        portIrq           // port irq
);
    logic [47:0] padQ;
    logic [2:0]  quiet;
    logic [47:0] portFn;
    always_comb begin
        for (int i = 0; i < 48; i++) begin
            portFn[i] = padFuncSel[2*i +: 2] == 2'h1;
        end
    end
    // edges since the pads last moved; bounds the two-stage sync delay
    always_ff @(posedge clock) begin
        padQ <= padIn;
        if (srst || padIn != padQ) begin
            quiet <= 3'h0;
        end else if (quiet != 3'h7) begin
            quiet <= quiet + 3'h1;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    a_ready_follows_ce:
        assert property (psel && penable && (pwrite || $past(psel && !pwrite && ce))
            |-> pready == ce) else $error("ready differs from enable");
    a_ready_needs_ce:
        assert property (pready |-> ce) else $error("ready while frozen");
    a_err_access_only:
        assert property (pslverr |-> psel && penable) else $error("error outside access");
    a_err_on_hole:
        assert property (psel && penable && paddr[15:12] < 4'h3 && paddr[11:10] == 2'h3
            |-> pslverr) else $error("hole not refused");
    a_reset_irq_quiet:
        assert property ($past(srst) |-> !combined_pad_irq && !portIrq && padOut == 48'h0
            && padOutEn == 48'h0) else $error("outputs active after reset");
    a_reset_pad_cfg:
        assert property ($past(srst) |-> padFuncSel == 96'h0 && (input_buffer_en
            & `GPP_PIN_PRESENT) == `GPP_PIN_PRESENT) else $error("pad setup after reset");
    a_oe_needs_port:
        assert property ((padOutEn & ~portFn) == 48'h0) else $error("drive without port fn");
    a_absent_pins_idle:
        assert property (((padOut | padOutEn) & ~`GPP_PIN_PRESENT) == 48'h0)
            else $error("absent pin active");
    a_latch_by_write:
        assert property (!$stable(padOut) |-> $past(psel && penable && pwrite && ce))
            else $error("latch moved without write");
    a_frozen_when_idle:
        assert property (!ce |=> $stable(padOut) && $stable(input_buffer_en))
            else $error("state moved while disabled");
    a_read_data_holds:
        assert property (!(psel && !pwrite && ce && !pready) |=> $stable(prdata))
            else $error("read data moved");
    a_irq_has_cause:
        assert property ($changed(combined_pad_irq) |-> quiet < 3'h5
            || $past(psel && penable && pwrite && ce)) else $error("pad irq without cause");
endmodule
bind gpp_top gpp_top_chk i_chk (.clock, .srst, .ce, .psel, .penable, .pwrite, .paddr,
    .prdata, .pready, .pslverr, .padIn, .padOut, .padOutEn, .padFuncSel,
    .input_buffer_en, .combined_pad_irq, .portIrq);
`default_nettype wire

// *** test/gpp_pad_model.sv ***
// Purpose: board side of the pads
// Assumes: bench commands the board drive per pad
// Notes:   undriven pads without pulls toggle, never keep a stale level
`timescale 1ns/1ns
`default_nettype none
module gpp_pad_model (
    input  wire logic        clock,       // clock
    input  wire logic [47:0] padOut,      // chip value
    input  wire logic [47:0] padOutEn,    // chip drives
    input  wire logic [47:0] pullup_en,   // pull-up
    input  wire logic [47:0] pulldown_en, // pull-down
    input  wire logic [47:0] extVal,      // board value
    input  wire logic [47:0] extEn,       // board drives
    output logic      [47:0] padIn        // pad level
);
    logic [47:0] wander = 48'h0000_0000_0000;
    always @(posedge clock) wander <= ~wander;
    assign padIn = (padOutEn & padOut) | (~padOutEn & extEn & extVal)
                 | (~padOutEn & ~extEn & (pullup_en | (~pulldown_en & wander)));
endmodule
`default_nettype wire

// *** test/gpp_top_bench.sv ***
// Purpose: self-checking bench of the gpio/pad block
// Assumes: pads settle two edges after a change
// Notes:   reads queue their expectation, a monitor compares at the access edge
`timescale 1ns/1ns
`default_nettype none
module gpp_top_bench import gpp_pkg::*;;
    logic        clock = 1'b0;
    logic        srst = 1'b1;
    logic        ce = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready, pslverr, combined_pad_irq, portIrq;
    logic [47:0] padIn, padOut, padOutEn, input_buffer_en, pullup_en, pulldown_en;
    logic [47:0] schmittSel, drive_strength_sel;
    logic [95:0] padFuncSel;
    logic [47:0] extVal = 48'h0000_0000_0000;
    logic [47:0] extEn = 48'hFFFF_FFFF_FFFF;
    logic [32:0] expq[$];
    logic [32:0] expNow;
    logic [31:0] seed = 32'h0000_0058;
    logic [15:0] lat;
    logic [7:0]  msk;
    int          numErrors = 0;
    int          checked = 0;
    always #5 clock = ~clock;
    gpp_top i_dut (.clock, .srst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .padIn, .padOut, .padOutEn, .padFuncSel, .input_buffer_en,
        .schmittSel, .pullup_en, .pulldown_en, .drive_strength_sel, .combined_pad_irq,
        .portIrq);
    gpp_pad_model i_pads (.clock, .padOut, .padOutEn, .pullup_en, .pulldown_en, .extVal,
        .extEn, .padIn);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        for (int i = 0; i < 16; i++) begin
            s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
        end
        return s;
    endfunction
    task automatic chk(input logic [47:0] got, input logic [47:0] want);
        checked++;
        if (got !== want) begin
            numErrors++;
            $display("[ERR] %0t output %h expected %h", $time, got, want);
        end
    endtask
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) expq.push_back(e);
        @(posedge clock);
        penable <= 1'b1;
        // no limit here: only the watchdog ends a wait
        do begin
            @(posedge clock);
        end while (!pready);
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    task automatic idle(input int c);
        repeat (c) @(posedge clock);
        #1;
    endtask
    task automatic setPads(input logic [47:0] v);
        @(posedge clock);
        extVal <= v;
        #1;
    endtask
    task automatic printVerdict;
        $display("errors %0d checks %0d", numErrors, checked);
        if (numErrors == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clock) begin
        if (psel && penable && pready && !pwrite) begin
            expNow = expq.pop_front();
            checked++;
            if ({pslverr, prdata} !== expNow) begin
                numErrors++;
                $display("[ERR] %0t read %h expected %h", $time, {pslverr, prdata}, expNow);
            end
        end
    end
    initial begin
        #200000;
        numErrors++;
        printVerdict;
    end
    initial begin
        repeat (6) @(posedge clock);
        srst <= 1'b0;
        apb(1'b0, 16'h3000, 32'h0, 33'h4);
        apb(1'b0, 16'h3100, 32'h0, 33'h0);
        apb(1'b0, 16'h3110, 32'h0, 33'h0);
        apb(1'b1, 16'h1004, 32'hFFFF, 33'h0);
        apb(1'b0, 16'h1004, 32'h0, 33'hF);
        seed = lfsr(seed);
        lat = seed[15:0] & 16'h7FFF;
        apb(1'b1, 16'h0004, {16'h0, lat}, 33'h0);
        apb(1'b1, 16'h0008, 32'h0003, 33'h0);
        apb(1'b1, 16'h000C, 32'h0300, 33'h0);
        lat = (lat | 16'h0003) & ~16'h0300;
        apb(1'b0, 16'h0008, 32'h0, 33'h0);
        chk({32'h0, padOut[15:0]}, {32'h0, lat});
        apb(1'b1, 16'h070C, 32'h0003, 33'h0);
        lat = (lat & ~16'h00C3) | 16'h0003;
        seed = lfsr(seed);
        msk = seed[7:0];
        apb(1'b1, 16'h0800 | {6'h0, msk, 2'h0}, {16'h0, seed[15:8], 8'h0}, 33'h0);
        lat = ((lat & ~{msk, 8'h0}) | ({seed[15:8], 8'h0} & {msk, 8'h0})) & 16'h7FFF;
        apb(1'b0, 16'h0004, 32'h0, {17'h0, lat});
        setPads({32'h0, seed[31:16]});
        idle(3);
        apb(1'b0, 16'h04F0, 32'h0, {25'h0, seed[23:16] & 8'h3C});
        apb(1'b0, 16'h0800 | {6'h0, msk, 2'h0}, 32'h0,
            {17'h0, seed[31:24] & msk & 8'h7F, 8'h0});
        apb(1'b1, 16'h3004, 32'h78, 33'h0);
        apb(1'b0, 16'h3004, 32'h0, 33'h78);
        chk(48'({drive_strength_sel[1], schmittSel[1], pullup_en[1], pulldown_en[1],
            input_buffer_en[1]}), 48'h1E);
        setPads({32'h0, seed[31:16] | 16'h0002});
        idle(3);
        apb(1'b0, 16'h0000, 32'h0, {17'h0, seed[30:16] & 15'h7FFD});
        apb(1'b1, 16'h0010, 32'h0004, 33'h0);
        apb(1'b1, 16'h3008, 32'h05, 33'h0);
        chk(48'(padFuncSel[5:4]), 48'h1);
        chk(48'(padOutEn[15:0]), 48'h4);
        apb(1'b1, 16'h3008, 32'h04, 33'h0);
        chk(48'(padOutEn[15:0]), 48'h0);
        apb(1'b1, 16'h3004, 32'h02, 33'h0);
        apb(1'b1, 16'h3100, 32'h2, 33'h0);
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, 16'h3110, {30'h0, k[0], 1'b0}, 33'h0);
            setPads({46'h0, k[1], 1'b0});
            idle(3);
            chk(48'(combined_pad_irq), 48'(k[0] ^ k[1]));
            apb(1'b0, 16'h3120, 32'h0, {31'h0, k[0] ^ k[1], 1'b0});
        end
        apb(1'b1, 16'h3100, 32'h0, 33'h0);
        chk(48'(combined_pad_irq), 48'h0);
        apb(1'b1, 16'h0014, 32'h8, 33'h0);
        for (int m = 1; m < 4; m++) begin
            apb(1'b1, 16'h0018, {28'h0, m[0], 3'h0}, 33'h0);
            apb(1'b1, 16'h001C, {28'h0, m[1], 3'h0}, 33'h0);
            setPads(48'h0);
            idle(3);
            apb(1'b1, 16'h0020, 32'hFFFF, 33'h0);
            setPads(48'h8);
            idle(4);
            apb(1'b0, 16'h0020, 32'h0, {29'h0, m[0], 3'h0});
            chk(48'(portIrq), 48'(m[0]));
            apb(1'b0, 16'h3130, 32'h0, {31'h0, m[0], 1'b0});
            apb(1'b1, 16'h0020, 32'h8, 33'h0);
            setPads(48'h0);
            idle(4);
            apb(1'b0, 16'h0020, 32'h0, {29'h0, m[1], 3'h0});
            chk(48'(portIrq), 48'(m[1]));
        end
        apb(1'b1, 16'h0014, 32'h0, 33'h0);
        apb(1'b1, 16'h0020, 32'hFFFF, 33'h0);
        setPads(48'h8);
        idle(4);
        chk(48'(portIrq), 48'h0);
        apb(1'b0, 16'h0020, 32'h0, 33'h8);
        apb(1'b0, 16'h0C00, 32'h0, {1'b1, 32'h0});
        @(posedge clock);
        ce <= 1'b0;
        fork
            apb(1'b1, 16'h0004, 32'h1234, 33'h0);
            begin
                repeat (4) @(posedge clock);
                ce <= 1'b1;
            end
        join
        apb(1'b0, 16'h0004, 32'h0, 33'h1234);
        printVerdict;
    end
endmodule
`default_nettype wire
